// >>> pcm_pkg.sv
// ****************************************************************
// Constants for the control and mode decode of the PWM unit
// ****************************************************************
package pcm_pkg;

    // ************************************************************
    // Bus widths and timing register count
    // ************************************************************
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int BYTE_W    = 8;
    localparam int TIMING_N  = 10;
    localparam int TIDX_W    = 4;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_TIMING_0  = 8'h04;
    localparam logic [7:0] ADDR_TIMING_9  = 8'h28;
    localparam logic [7:0] ADDR_STATUS    = 8'h2C;

    // ************************************************************
    // Control register fields and reset value
    // ************************************************************
    localparam int BIT_ENABLE    = 7;
    localparam int BIT_LOAD      = 6;
    localparam int BIT_FALL_DB   = 5;
    localparam int BIT_RISE_DB   = 4;
    localparam int MODE_HI       = 3;
    localparam int MODE_LO       = 0;
    localparam int MODE_W        = 4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] TIMING_RESET  = 8'h00;

    // ************************************************************
    // Operating mode codes
    // ************************************************************
    localparam logic [3:0] MODE_SINGLE          = 4'h0;
    localparam logic [3:0] MODE_PULSE_SKIP_COMP = 4'h7;
    localparam logic [3:0] MODE_BRIDGE_REV      = 4'h8;
    localparam logic [3:0] MODE_BRIDGE_FWD      = 4'h9;
    localparam logic [3:0] MODE_FIXED_SINGLE    = 4'hA;
    localparam logic [3:0] MODE_FIXED_COMP      = 4'hB;
    localparam logic [3:0] MODE_THREE_PHASE     = 4'hC;
    localparam logic [3:0] MODE_LAST_VALID      = 4'hC;

    // ************************************************************
    // Style vector: one bit per valid mode code, plus reserved
    // ************************************************************
    localparam int STYLE_W        = 14;
    localparam int STYLE_RESERVED = 13;

    // Bus handshake phases of the slave
    typedef enum logic [1:0] {
        PCM_IDLE,
        PCM_WAIT,
        PCM_DONE
    } pcm_phase_t;

endpackage

// >>> pcm_timing_bank.sv
`timescale 1ns/1ns
// ****************************************************************
// Holding and active copies of the buffered timing registers
// ****************************************************************
module pcm_timing_bank
    import pcm_pkg::*;
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            wr_en,
    input  wire logic [TIDX_W-1:0]               wr_idx,
    input  wire logic [BYTE_W-1:0]               wr_data,
    input  wire logic                            direct,
    input  wire logic                            load_all,
    input  wire logic [TIDX_W-1:0]               rd_idx,
    output logic      [BYTE_W-1:0]               rd_data,
    output logic      [TIMING_N-1:0][BYTE_W-1:0] act_words
);

    logic [TIMING_N-1:0][BYTE_W-1:0] hold_reg;
    logic [TIMING_N-1:0][BYTE_W-1:0] hold_next;
    logic [TIMING_N-1:0][BYTE_W-1:0] act_reg;
    logic [TIMING_N-1:0][BYTE_W-1:0] act_next;
    logic [BYTE_W-1:0]               rd_data_reg;

    // Next values of holding and active words
    always_comb begin
        hold_next = hold_reg;
        act_next  = act_reg;
        if (load_all) begin
            act_next = hold_reg;
        end
        if (wr_en) begin
            hold_next[wr_idx] = wr_data;
            if (direct) begin
                act_next[wr_idx] = wr_data;
            end
        end
    end

    // Storage, read data out of a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg    <= '0;
            act_reg     <= '0;
            rd_data_reg <= TIMING_RESET;
        end else begin
            hold_reg    <= hold_next;
            act_reg     <= act_next;
            rd_data_reg <= (rd_idx < TIMING_N) ? hold_reg[rd_idx]
                                               : TIMING_RESET;
        end
    end

    assign rd_data   = rd_data_reg;
    assign act_words = act_reg;

endmodule

// >>> pcm_control.sv
`timescale 1ns/1ns
// Behaviour
// - Falling dead band follows its enable bit
// - Rising dead band follows its enable bit
// - Four-bit low field selects waveform style
// - Code 1100 gives three-phase steering
// - Code 1011 fixed duty, complementary pair
// - Code 1010 fixed duty, single output
// - Code 1001 full bridge forward
// - Code 1000 full bridge reverse
// - Code 0111 pulse skipping with complement
// - Enabled load request moves buffers at period
// - Hardware clears load request when transfer done
// - Disabled writes also load active buffers
// ****************************************************************
// Control register, buffered timing words and mode decode
// ****************************************************************
module pcm_control
    import pcm_pkg::*;
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [ADDR_W-1:0]               paddr,
    input  wire logic [DATA_W-1:0]               pwdata,
    output logic      [DATA_W-1:0]               prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            period_event,
    output logic                                 module_enable,
    output logic                                 buffer_load_done,
    output logic      [MODE_W-1:0]               output_mode_select,
    output logic                                 falling_deadband_enable,
    output logic                                 rising_deadband_enable,
    output logic      [STYLE_W-1:0]              style_select,
    output logic      [TIMING_N-1:0][BYTE_W-1:0] timing_active
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Word index of a timing register address
    function automatic logic [TIDX_W-1:0] timing_index(
        input logic [ADDR_W-1:0] addr
    );
        logic [ADDR_W-1:0] diff;
        diff = addr - ADDR_TIMING_0;
        timing_index = diff[TIDX_W+1:2];
    endfunction

    // Address lies in the timing register window
    function automatic logic is_timing(
        input logic [ADDR_W-1:0] addr
    );
        is_timing = (addr >= ADDR_TIMING_0) && (addr <= ADDR_TIMING_9)
                    && (addr[1:0] == 2'h0);
    endfunction

    // One-hot style from a mode code; reserved codes flag alone
    function automatic logic [STYLE_W-1:0] style_of(
        input logic [MODE_W-1:0] mode
    );
        logic [STYLE_W-1:0] v;
        v = '0;
        // Named codes first, push-pull and steering codes by index
        case (mode)
            MODE_THREE_PHASE:     v[MODE_THREE_PHASE]     = 1'b1;
            MODE_FIXED_COMP:      v[MODE_FIXED_COMP]      = 1'b1;
            MODE_FIXED_SINGLE:    v[MODE_FIXED_SINGLE]    = 1'b1;
            MODE_BRIDGE_FWD:      v[MODE_BRIDGE_FWD]      = 1'b1;
            MODE_BRIDGE_REV:      v[MODE_BRIDGE_REV]      = 1'b1;
            MODE_PULSE_SKIP_COMP: v[MODE_PULSE_SKIP_COMP] = 1'b1;
            default: begin
                if (mode <= MODE_LAST_VALID) begin
                    v[mode] = 1'b1;
                end else begin
                    v[STYLE_RESERVED] = 1'b1;
                end
            end
        endcase
        style_of = v;
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    pcm_phase_t          phase_reg;
    pcm_phase_t          phase_next;
    logic [DATA_W-1:0]   prdata_reg;
    logic [DATA_W-1:0]   prdata_next;
    logic                pslverr_reg;
    logic                pslverr_next;
    logic                pready_reg;

    logic                en_reg;
    logic                ld_reg;
    logic                ld_next;
    logic                fall_db_reg;
    logic                rise_db_reg;
    logic [MODE_W-1:0]   mode_reg;

    logic                act_fall_db_reg;
    logic                act_rise_db_reg;
    logic [MODE_W-1:0]   act_mode_reg;
    logic [STYLE_W-1:0]  style_reg;
    logic                load_done_reg;

    // Style shown from reset: the decode of the reset mode code
    localparam logic [STYLE_W-1:0] STYLE_RESET =
        style_of(CONTROL_RESET[MODE_HI:MODE_LO]);

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire logic                access_ph;
    wire logic                done;
    wire logic                wr_done;
    wire logic                sel_control;
    wire logic                sel_status;
    wire logic                sel_timing;
    wire logic                mapped;
    wire logic                ctrl_wr;
    wire logic                timing_wr;
    wire logic [TIDX_W-1:0]   tidx;
    wire logic [BYTE_W-1:0]   bank_rdata;
    wire logic [BYTE_W-1:0]   control_value;
    wire logic [BYTE_W-1:0]   status_value;
    wire logic                xfer;
    wire logic                apply_now;
    wire logic                ready_next;

    // Access qualifiers and address matches
    assign access_ph   = psel && penable;
    assign done        = access_ph && (phase_reg == PCM_DONE);
    assign wr_done     = done && pwrite;
    assign sel_control = (paddr == ADDR_CONTROL);
    assign sel_status  = (paddr == ADDR_STATUS);
    assign sel_timing  = is_timing(paddr);
    assign mapped      = sel_control || sel_status || sel_timing;
    assign ctrl_wr     = wr_done && sel_control;
    assign timing_wr   = wr_done && sel_timing;
    assign tidx        = timing_index(paddr);

    // Readback images of control and applied state
    assign control_value = {en_reg, ld_reg, fall_db_reg, rise_db_reg,
                            mode_reg};
    assign status_value  = {en_reg, 1'b0, act_fall_db_reg,
                            act_rise_db_reg, act_mode_reg};

    // Buffer transfer and applying moments
    assign xfer      = en_reg && ld_reg && period_event;
    assign apply_now = !en_reg || period_event;

    // Ready is registered so that the bus sees a clean flop output
    assign ready_next = (phase_next == PCM_DONE);

    // ************************************************************
    // Bus handshake: setup, two wait cycles, then pready
    // ************************************************************
    always_comb begin
        phase_next   = phase_reg;
        prdata_next  = prdata_reg;
        pslverr_next = pslverr_reg;
        case (phase_reg)
            PCM_IDLE: begin
                if (access_ph) begin
                    phase_next = PCM_WAIT;
                end
            end
            PCM_WAIT: begin
                phase_next   = PCM_DONE;
                pslverr_next = !mapped;
                prdata_next  = '0;
                if (!pwrite && sel_control) begin
                    prdata_next[BYTE_W-1:0] = control_value;
                end else if (!pwrite && sel_status) begin
                    prdata_next[BYTE_W-1:0] = status_value;
                end else if (!pwrite && sel_timing) begin
                    prdata_next[BYTE_W-1:0] = bank_rdata;
                end
            end
            PCM_DONE: begin
                phase_next   = PCM_IDLE;
                pslverr_next = 1'b0;
            end
            default: begin
                phase_next = PCM_IDLE;
            end
        endcase
    end

    // Handshake registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg   <= PCM_IDLE;
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
            pready_reg  <= 1'b0;
        end else begin
            phase_reg   <= phase_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
            pready_reg  <= ready_next;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************

    // Load request: software write loads the bit, transfer clears, write wins
    always_comb begin
        if (ctrl_wr) begin
            ld_next = pwdata[BIT_LOAD];
        end else if (xfer) begin
            ld_next = 1'b0;
        end else begin
            ld_next = ld_reg;
        end
    end

    // Software fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg      <= CONTROL_RESET[BIT_ENABLE];
            ld_reg      <= CONTROL_RESET[BIT_LOAD];
            fall_db_reg <= CONTROL_RESET[BIT_FALL_DB];
            rise_db_reg <= CONTROL_RESET[BIT_RISE_DB];
            mode_reg    <= CONTROL_RESET[MODE_HI:MODE_LO];
        end else begin
            ld_reg <= ld_next;
            if (ctrl_wr) begin
                en_reg      <= pwdata[BIT_ENABLE];
                fall_db_reg <= pwdata[BIT_FALL_DB];
                rise_db_reg <= pwdata[BIT_RISE_DB];
                mode_reg    <= pwdata[MODE_HI:MODE_LO];
            end
        end
    end

    // ************************************************************
    // Applied mode and dead band, changed at period edges while enabled, at once while disabled
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_fall_db_reg <= CONTROL_RESET[BIT_FALL_DB];
            act_rise_db_reg <= CONTROL_RESET[BIT_RISE_DB];
            act_mode_reg    <= CONTROL_RESET[MODE_HI:MODE_LO];
            style_reg       <= STYLE_RESET;
        end else if (apply_now) begin
            act_fall_db_reg <= fall_db_reg;
            act_rise_db_reg <= rise_db_reg;
            act_mode_reg    <= mode_reg;
            style_reg       <= style_of(mode_reg);
        end
    end

    // Reserved codes above 1100 raise only the reserved style bit,
    // so the output stage can park its pins for them instead of
    // guessing at a waveform; every other code owns one style bit
    // and the steering logic needs no decode of its own

    // Completion pulse for the buffer transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_done_reg <= 1'b0;
        end else begin
            load_done_reg <= xfer;
        end
    end

    // ************************************************************
    // Buffered timing words
    // ************************************************************
    pcm_timing_bank u_bank (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (timing_wr),
        .wr_idx    (tidx),
        .wr_data   (pwdata[BYTE_W-1:0]),
        .direct    (!en_reg),
        .load_all  (xfer),
        .rd_idx    (tidx),
        .rd_data   (bank_rdata),
        .act_words (timing_active)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata                  = prdata_reg;
    assign pready                  = pready_reg;
    assign pslverr                 = pslverr_reg;
    assign module_enable           = en_reg;
    assign buffer_load_done        = load_done_reg;
    assign output_mode_select      = act_mode_reg;
    assign falling_deadband_enable = act_fall_db_reg;
    assign rising_deadband_enable  = act_rise_db_reg;
    assign style_select            = style_reg;

endmodule

// >>> pcm_control_asserts.sv
`timescale 1ns/1ns
// ************************************************************
// Port checker for the control and mode decode
// ************************************************************
module pcm_control_chk
    import pcm_pkg::*;
(
    input wire logic                            pclk,
    input wire logic                            presetn,
    input wire logic [DATA_W-1:0]               prdata,
    input wire logic                            pready,
    input wire logic                            pslverr,
    input wire logic                            period_event,
    input wire logic                            module_enable,
    input wire logic                            buffer_load_done,
    input wire logic [MODE_W-1:0]               output_mode_select,
    input wire logic                            falling_deadband_enable,
    input wire logic                            rising_deadband_enable,
    input wire logic [STYLE_W-1:0]              style_select,
    input wire logic [TIMING_N-1:0][BYTE_W-1:0] timing_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // One-hot style expected from the applied mode
    wire logic [STYLE_W-1:0] style_exp;
    assign style_exp = (output_mode_select <= MODE_LAST_VALID)
        ? (STYLE_W'(1) << output_mode_select)
        : (STYLE_W'(1) << STYLE_RESERVED);

    // Enabled and no period boundary: nothing may be applied
    sequence quiet_s;
        module_enable && !period_event;
    endsequence

    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready high for more than one cycle");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    style_decode_a: assert property (style_select == style_exp)
        else $error("style select does not match mode");
    mode_hold_a: assert property (
        quiet_s |=> $stable(output_mode_select))
        else $error("mode changed off a period boundary");
    deadband_hold_a: assert property (
        quiet_s |=>
        $stable({falling_deadband_enable, rising_deadband_enable}))
        else $error("dead band changed off a period boundary");
    active_hold_a: assert property (
        quiet_s |=> $stable(timing_active))
        else $error("active timing changed while enabled");
    load_done_a: assert property (
        buffer_load_done |-> $past(period_event))
        else $error("load done without a period event");
    load_disabled_a: assert property (
        !module_enable |=> !buffer_load_done)
        else $error("load done while the module is disabled");
endmodule

bind pcm_control pcm_control_chk u_pcm_control_chk (
    .pclk(pclk), .presetn(presetn), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .period_event(period_event),
    .module_enable(module_enable), .buffer_load_done(buffer_load_done),
    .output_mode_select(output_mode_select),
    .falling_deadband_enable(falling_deadband_enable),
    .rising_deadband_enable(rising_deadband_enable),
    .style_select(style_select), .timing_active(timing_active)
);

// >>> tb_top.sv
`timescale 1ns/1ns
// ************************************************************
// Self-checking bench for the control and mode decode
// ************************************************************
module tb_top
    import pcm_pkg::*;
;
    logic                            pclk, presetn, psel, penable, pwrite;
    logic                            pready, pslverr, period_event, err, seen;
    logic                            module_enable, buffer_load_done;
    logic                            falling_deadband_enable;
    logic                            rising_deadband_enable;
    logic [ADDR_W-1:0]               paddr;
    logic [DATA_W-1:0]               pwdata, prdata, rd;
    logic [MODE_W-1:0]               output_mode_select;
    logic [STYLE_W-1:0]              style_select;
    logic [TIMING_N-1:0][BYTE_W-1:0] timing_active, act_exp, nxt_exp;
    logic [7:0]                      ctl;
    int                              seed = 1;
    int                              num_errors = 0;
    int                              samples_checked = 0;

    pcm_control u_pcm_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .period_event(period_event),
        .module_enable(module_enable), .buffer_load_done(buffer_load_done),
        .output_mode_select(output_mode_select),
        .falling_deadband_enable(falling_deadband_enable),
        .rising_deadband_enable(rising_deadband_enable),
        .style_select(style_select), .timing_active(timing_active)
    );

    // Clock of 100 ns period
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    // ********************************************************
    // Helpers
    // ********************************************************
    task check(input string name, input logic [31:0] seen_v, exp_v);
        samples_checked++;
        if (seen_v !== exp_v) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask

    task final_report;
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One APB transfer, then one idle cycle; the watchdog ends a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Period event pulse, load done captured over three cycles
    task pulse;
        seen = 1'b0;
        period_event <= 1'b1;
        @(posedge pclk);
        period_event <= 1'b0;
        repeat (3) begin
            @(posedge pclk);
            seen = seen | buffer_load_done;
        end
    endtask

    function logic [31:0] style_of(input logic [3:0] m);
        return (m <= MODE_LAST_VALID) ? 32'h1 << m : 32'h1 << STYLE_RESERVED;
    endfunction

    task check_applied(input logic [7:0] c);
        check("mode", 32'(output_mode_select), 32'(c[3:0]));
        check("fall", 32'(falling_deadband_enable), 32'(c[5]));
        check("rise", 32'(rising_deadband_enable), 32'(c[4]));
        check("enable", 32'(module_enable), 32'(c[7]));
        check("style", 32'(style_select),
              style_of(c[3:0]));
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("status", rd, {24'h0, c[7], 1'b0, c[5:0]});
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, period_event} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("style_rst", 32'(style_select), 32'h1);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("ctl_rst", rd, 32'h0);
        apb(1'b1, 8'h30, 32'hFF);
        check("slverr_w", 32'(err), 32'h1);
        apb(1'b0, 8'h30, 32'h0);
        check("slverr_r", 32'(err), 32'h1);
        check("unmapped", rd, 32'h0);
        // Every valid mode code while disabled, random dead band bits
        for (int m = 0; m <= MODE_LAST_VALID; m++) begin
            ctl = {2'b00, 2'($random(seed)), 4'(m)};
            apb(1'b1, ADDR_CONTROL, {24'h0, ctl});
            @(posedge pclk);
            check_applied(ctl);
        end
        // Disabled timing writes reach the active words at once
        for (int i = 0; i < TIMING_N; i++) begin
            act_exp[i] = 8'($random(seed));
            nxt_exp[i] = 8'($random(seed));
            apb(1'b1, ADDR_TIMING_0 + 8'(4 * i), {24'h0, act_exp[i]});
            check("act_dis", 32'(timing_active[i]), 32'(act_exp[i]));
        end
        apb(1'b0, ADDR_TIMING_9, 32'h0);
        check("hold_rd", rd, {24'h0, act_exp[9]});
        // Enable in three-phase mode, applied at the period event
        apb(1'b1, ADDR_CONTROL, 32'h8C);
        pulse;
        check("done_noload", 32'(seen), 32'h0);
        check_applied(8'h8C);
        // Enabled writes stay in the holding copies
        for (int i = 0; i < TIMING_N; i++)
            apb(1'b1, ADDR_TIMING_0 + 8'(4 * i), {24'h0, nxt_exp[i]});
        apb(1'b1, ADDR_CONTROL, 32'hB7);
        repeat (2) @(posedge pclk);
        check("mode_hold", 32'(output_mode_select), 32'hC);
        check("act_hold", 32'(timing_active === act_exp), 32'h1);
        // Load request moves all words at the next period event
        apb(1'b1, ADDR_CONTROL, 32'hF7);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("ld_pend", rd, 32'hF7);
        pulse;
        check("load_done", 32'(seen), 32'h1);
        check("act_load", 32'(timing_active === nxt_exp), 32'h1);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("ld_clear", rd, 32'hB7);
        check_applied(8'hB7);
        // Status is read only
        apb(1'b1, ADDR_STATUS, 32'h00);
        check("stat_err", 32'(err), 32'h0);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("ctl_keep", rd, 32'hB7);
        // Reset in mid-run brings back every reset value
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("en_rst", 32'(module_enable), 32'h0);
        check("style_rst2", 32'(style_select), 32'h1);
        check("act_rst", 32'(timing_active === '0), 32'h1);
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check("ctl_rst2", rd, 32'h0);
        final_report;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        final_report;
    end
endmodule
